//--- inc/board_test_pkg.sv
// Constants for the board test control block: address map, field positions,
// reset values and test mode 0 addresses.
// Assumes the parallel microprocessor port with an 8-bit address and data.
`default_nettype none
package board_test_pkg;
  localparam logic [7:0] normal_last_addr = 8'h7F;
  localparam logic [7:0] test_feature_control_addr = 8'h80;
  localparam int test_select_bit = 7;
  localparam int outputs_float_bit = 0;
  localparam int data_bus_float_bit = 1;
  localparam int board_io_test_bit = 2;
  localparam int bus_drive_by_select_bit = 3;
  localparam int factory_test_mode_bit = 4;
  localparam logic [4:0] control_reset_value = 5'h00;
  localparam logic [7:0] unused_read_value = 8'h00;
  // Test mode 0 input read addresses and output force addresses.
  localparam logic [7:0] tm0_in_lo_addr = 8'h90;
  localparam logic [7:0] tm0_in_hi_addr = 8'h92;
  localparam logic [7:0] tm0_out_lo_addr = 8'h96;
  localparam logic [7:0] tm0_out_hi_addr = 8'h98;
  // Sub-block test mode 0 enable registers, written with zero to enter.
  localparam int tm0_enable_count = 8;
  localparam logic [7:0] tm0_enable_addr [tm0_enable_count] = '{
    8'h91, 8'h95, 8'h99, 8'hA1, 8'hB1, 8'hC1, 8'hD1, 8'hE1};
endpackage
`default_nettype wire

//--- rtl/board_test_control.sv
// Board test control: master test register, tri-state control of the
// device pins and data bus, test register decode and test mode 0 access.
// Assumes strobes are synchronous to mclk_in; boundary scan runs on mclk_in and samples tck_in.
//
// Contract
// (RULE_01) All three strobes low floats digital outputs and data bus.
// (RULE_02) Address bit 7 high selects the test register space.
// (RULE_03) 0x00-0x7F normal, 0x80 master test, 0x81-0xFF test.
// (RULE_04) Writes to unused test bits do nothing; reads return anything.
// (RULE_05) Host writes zero to unused bits and masks them on read.
// (RULE_06) Writable test bits keep their value over reset unless stated.
// (RULE_07) Reset clears master test bits except factory test mode.
// (RULE_08) Outputs float flag floats all outputs but data bus and scan out.
// (RULE_09) Data bus float flag also floats the data bus.
// (RULE_10) Board I/O test holds sub-blocks in test mode 0 access.
// (RULE_11) Test mode 0 reads input levels and forces output levels.
// (RULE_12) Bus drive by select: chip select high drives, low floats bus.
// (RULE_13) Bus drive by select overrides the data bus float flag.
// (RULE_14) Factory test mode turns the port into a vector access port.
// (RULE_15) Factory test mode ORed with board I/O test for test mode.
// (RULE_16) Factory test mode clears only by chip select high.
// (RULE_17) Boundary scan port reads inputs and forces outputs.
// (RULE_18) Host enters test mode 0 by zero writes to eight addresses.
// (RULE_19) Test accesses use the normal strobe and bus protocol.
`timescale 1ns/1ps
`default_nettype none
module board_test_control
  import board_test_pkg::*;
(
  input wire logic mclk_in, // 10 MHz system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic cs_n_in, // chip select, active low
  input wire logic rd_n_in, // read strobe, active low
  input wire logic wr_n_in, // write strobe, active low
  input wire logic [7:0] addr_in, // register address
  input wire logic [7:0] data_in, // data bus input
  input wire logic [7:0] normal_rdata_in, // normal register read data
  input wire logic [15:0] pin_level_in, // device input pin levels
  input wire logic [15:0] func_out_in, // functional output values
  input wire logic tck_in, // scan clock, sampled
  input wire logic tms_in, // scan mode select
  input wire logic tdi_in, // scan data in
  input wire logic trst_n_in, // scan reset, active low
  output logic [7:0] data_out, // data bus output
  output logic data_oe_out, // data bus output enable
  output logic normal_wr_out, // write pulse to normal registers
  output logic [15:0] pin_out, // device output pin values
  output logic pin_oe_out, // device output pins enable
  output logic subblock_test_out, // sub-blocks held in test mode
  output logic factory_test_out, // port used as vector access port
  output logic tdo_out, // scan data out
  output logic tdo_oe_out // scan data out enable
);

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  function automatic logic tm0_enable_hit(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < tm0_enable_count; i++) begin
      if (a == tm0_enable_addr[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [4:0] ctrl_reg;
  logic [4:0] ctrl_next;
  logic [7:0] tm0_en_reg;
  logic [7:0] tm0_en_next;
  logic [15:0] force_reg;
  logic [15:0] force_next;
  logic wr_d_reg;
  logic [7:0] data_out_next;
  logic data_oe_next;
  logic pin_oe_next;
  logic normal_wr_next;

  wire strobes_all_low = !cs_n_in && !rd_n_in && !wr_n_in; // RULE_01
  wire rd_active = !cs_n_in && !rd_n_in && wr_n_in; // RULE_19
  wire wr_active = !cs_n_in && !wr_n_in && rd_n_in; // RULE_19
  wire wr_pulse = wr_active && !wr_d_reg;
  wire test_space = addr_in[test_select_bit]; // RULE_02
  wire master_hit = addr_in == test_feature_control_addr; // RULE_03
  wire test_mode = ctrl_reg[board_io_test_bit]
    || ctrl_reg[factory_test_mode_bit]; // RULE_15
  wire tm0_all_on = &tm0_en_reg;
  wire tm0_en_write = wr_pulse && test_space && test_mode
    && tm0_enable_hit(addr_in); // RULE_10

  // ----------------------------------------------------------------------
  // Master test register
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_pulse && test_space && master_hit) begin
      // Bits 7..5 are dropped; factory test mode can only be set here.
      ctrl_next[3:0] = data_in[3:0]; // RULE_04
      if (data_in[factory_test_mode_bit]) begin
        ctrl_next[factory_test_mode_bit] = 1'b1; // RULE_16
      end
    end
    if (cs_n_in) begin
      ctrl_next[factory_test_mode_bit] = 1'b0; // RULE_16
    end
    if (!rst_n_in) begin
      ctrl_next[3:0] = control_reset_value[3:0]; // RULE_07
    end
  end

  // Test mode 0 enables and forced outputs keep their value over reset.
  always_comb begin
    tm0_en_next = tm0_en_reg; // RULE_06
    force_next = force_reg;
    if (wr_pulse && test_space && test_mode) begin // RULE_10
      for (int i = 0; i < tm0_enable_count; i++) begin
        if (tm0_en_write && addr_in == tm0_enable_addr[i]) begin
          tm0_en_next[i] = (data_in == 8'h00); // RULE_18
        end
      end
      if (addr_in == tm0_out_lo_addr) begin
        force_next[7:0] = data_in; // RULE_11
      end
      if (addr_in == tm0_out_hi_addr) begin
        force_next[15:8] = data_in; // RULE_11
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data and drive enables
  // ----------------------------------------------------------------------
  wire [7:0] test_rdata =
    master_hit ? {3'b000, ctrl_reg} :
    (addr_in == tm0_in_lo_addr && tm0_all_on) ? pin_level_in[7:0] :
    (addr_in == tm0_in_hi_addr && tm0_all_on) ? pin_level_in[15:8] :
    unused_read_value; // RULE_04
  wire read_drive = rd_active && !ctrl_reg[data_bus_float_bit]; // RULE_09
  wire bus_drive = ctrl_reg[bus_drive_by_select_bit] ?
    cs_n_in : read_drive; // RULE_12 RULE_13

  always_comb begin
    data_out_next = test_space ? test_rdata : normal_rdata_in; // RULE_02
    data_oe_next = bus_drive && !strobes_all_low; // RULE_01
    pin_oe_next = !ctrl_reg[outputs_float_bit]
      && !strobes_all_low; // RULE_08 RULE_01
    normal_wr_next = wr_pulse && !test_space; // RULE_03
    if (!rst_n_in) begin
      data_oe_next = 1'b0;
      normal_wr_next = 1'b0;
    end
  end

  wire tm0_drive = test_mode && tm0_all_on; // RULE_11

  // ----------------------------------------------------------------------
  // Boundary scan: 3-bit instruction and 32-bit capture chain
  // ----------------------------------------------------------------------
  typedef enum {tap_reset, tap_idle, tap_shift_dr, tap_shift_ir,
    tap_update} tap_state_t;
  tap_state_t tap_reg;
  tap_state_t tap_next;
  logic tck_d_reg;
  logic [2:0] ir_reg;
  logic [31:0] bsr_reg;
  logic [31:0] bsr_hold_reg;
  logic extest_reg;
  wire tck_rise = tck_in && !tck_d_reg;

  always_comb begin
    case (tap_reg)
      tap_reset: tap_next = tms_in ? tap_reset : tap_idle;
      tap_idle: tap_next = tms_in ? tap_shift_dr : tap_idle;
      tap_shift_dr: tap_next = tms_in ? tap_update : tap_shift_dr;
      tap_shift_ir: tap_next = tms_in ? tap_update : tap_shift_ir;
      tap_update: tap_next = tms_in ? tap_shift_ir : tap_idle;
      default: tap_next = tap_reset;
    endcase
  end

  // Simplified walk; the full sixteen-state controller is not needed here.
  always_ff @(posedge mclk_in) begin
    tck_d_reg <= tck_in;
    if (!rst_n_in || !trst_n_in) begin
      tap_reg <= tap_reset;
      ir_reg <= 3'h1;
      extest_reg <= 1'b0;
      bsr_reg <= 32'h0000_0000;
      bsr_hold_reg <= 32'h0000_0000;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
      if (tap_reg == tap_idle) begin
        bsr_reg <= {pin_level_in, func_out_in}; // RULE_17
      end
      if (tap_reg == tap_shift_dr) begin
        bsr_reg <= {tdi_in, bsr_reg[31:1]}; // RULE_17
      end
      if (tap_reg == tap_shift_ir) begin
        ir_reg <= {tdi_in, ir_reg[2:1]};
      end
      if (tap_reg == tap_update) begin
        bsr_hold_reg <= bsr_reg;
        extest_reg <= (ir_reg == 3'h0);
      end
    end
  end

  wire [15:0] pin_value = extest_reg ? bsr_hold_reg[15:0] :
    tm0_drive ? force_reg : func_out_in; // RULE_17 RULE_11

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    ctrl_reg <= ctrl_next;
    tm0_en_reg <= tm0_en_next;
    force_reg <= force_next;
    wr_d_reg <= rst_n_in ? wr_active : 1'b0;
    data_out <= data_out_next;
    data_oe_out <= data_oe_next;
    pin_oe_out <= pin_oe_next;
    normal_wr_out <= normal_wr_next;
    pin_out <= pin_value;
    subblock_test_out <= test_mode; // RULE_10 RULE_15
    factory_test_out <= ctrl_reg[factory_test_mode_bit]; // RULE_14
    tdo_out <= (tap_reg == tap_shift_ir) ? ir_reg[0] : bsr_reg[0];
    // The scan output is a digital pin too, so the strobe test floats it.
    tdo_oe_out <= ((tap_reg == tap_shift_dr) || (tap_reg == tap_shift_ir))
      && !strobes_all_low; // RULE_01
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Test mode 0 enables and forced values power up unknown on purpose, so
  // no check here compares them directly.
  strobe_float_a: assert property ( // RULE_01
    @(posedge mclk_in) disable iff (!rst_n_in)
    strobes_all_low |=> !data_oe_out && !pin_oe_out)
    else $error("strobe combination did not float outputs");
  scan_float_a: assert property ( // RULE_01
    @(posedge mclk_in) disable iff (!rst_n_in)
    strobes_all_low |=> !tdo_oe_out)
    else $error("strobe combination did not float scan data out");
  reset_clear_a: assert property ( // RULE_07
    @(posedge mclk_in)
    !rst_n_in |=> ctrl_reg[3:0] == 4'h0)
    else $error("reset did not clear master test bits");
  factory_hold_a: assert property ( // RULE_16
    @(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_reg[factory_test_mode_bit] && !cs_n_in
    |=> ctrl_reg[factory_test_mode_bit])
    else $error("factory test mode cleared without chip select high");
  factory_clear_a: assert property ( // RULE_16
    @(posedge mclk_in)
    cs_n_in |=> !ctrl_reg[factory_test_mode_bit])
    else $error("factory test mode survived chip select high");
  factory_set_a: assert property ( // RULE_16
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_pulse && test_space && master_hit && data_in[factory_test_mode_bit]
    |=> ctrl_reg[factory_test_mode_bit])
    else $error("factory test mode not set by write");
  factory_out_a: assert property ( // RULE_14
    @(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_reg[factory_test_mode_bit] |=> factory_test_out)
    else $error("vector access port not flagged");
  outputs_float_a: assert property ( // RULE_08
    @(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_reg[outputs_float_bit] |=> !pin_oe_out)
    else $error("outputs driven while outputs float set");
  bus_select_a: assert property ( // RULE_12 RULE_13
    @(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_reg[bus_drive_by_select_bit] && !strobes_all_low
    |=> data_oe_out == $past(cs_n_in))
    else $error("data bus enable does not follow chip select");
  bus_float_a: assert property ( // RULE_09
    @(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_reg[data_bus_float_bit] && !ctrl_reg[bus_drive_by_select_bit]
    |=> !data_oe_out)
    else $error("data bus driven while data bus float set");
  read_drive_a: assert property ( // RULE_19
    @(posedge mclk_in) disable iff (!rst_n_in)
    rd_active && !ctrl_reg[data_bus_float_bit]
    && !ctrl_reg[bus_drive_by_select_bit] |=> data_oe_out)
    else $error("read cycle did not drive the data bus");
  test_mode_a: assert property ( // RULE_15
    @(posedge mclk_in) disable iff (!rst_n_in)
    test_mode |=> subblock_test_out)
    else $error("sub-blocks not placed in test mode");
  subblock_clear_a: assert property ( // RULE_15
    @(posedge mclk_in) disable iff (!rst_n_in)
    !test_mode |=> !subblock_test_out)
    else $error("sub-blocks held in test mode with both bits clear");
  normal_write_a: assert property ( // RULE_02
    @(posedge mclk_in) disable iff (!rst_n_in)
    normal_wr_out |-> !$past(addr_in[test_select_bit]))
    else $error("normal write issued for test address");
  normal_read_a: assert property ( // RULE_02
    @(posedge mclk_in) disable iff (!rst_n_in)
    rd_active && !test_space |=> data_out == $past(normal_rdata_in))
    else $error("normal read did not return normal register data");
  master_write_a: assert property ( // RULE_03
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_pulse && test_space && master_hit
    |=> ctrl_reg[3:0] == $past(data_in[3:0]))
    else $error("master test write did not land");
  master_read_a: assert property ( // RULE_03
    @(posedge mclk_in) disable iff (!rst_n_in)
    rd_active && master_hit |=> data_out == {3'b000, $past(ctrl_reg)})
    else $error("master test read returned wrong data");
  extest_pins_a: assert property ( // RULE_17
    @(posedge mclk_in) disable iff (!rst_n_in)
    extest_reg |=> pin_out == $past(bsr_hold_reg[15:0]))
    else $error("pins do not follow the scan update register");
  func_pins_a: assert property ( // RULE_10
    @(posedge mclk_in) disable iff (!rst_n_in)
    !extest_reg && !test_mode |=> pin_out == $past(func_out_in))
    else $error("pins do not carry functional values");

endmodule // board_test_control
`default_nettype wire

//--- sim/host_port_model.sv
// Host port model: a microprocessor or board tester on the parallel port.
// Assumes tasks are called after reset release, one at a time.
`timescale 1ns/1ps
`default_nettype none
module host_port_model
  import board_test_pkg::*;
(
  input wire logic mclk_in, // system clock
  input wire logic [7:0] rd_data_in, // data bus from device
  input wire logic rd_oe_in, // data bus enable from device
  output var logic cs_n_out, // chip select, active low
  output var logic rd_n_out, // read strobe, active low
  output var logic wr_n_out, // write strobe, active low
  output var logic [7:0] addr_out, // address
  output var logic [7:0] wdata_out // write data
);
  bit keep_cs = 1'b0;
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // Stale data is inverted so a held value never looks like fresh data.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    addr_out = a;
    wdata_out = d;
    @(posedge mclk_in);
    #1;
    wr_n_out = 1'b1;
    wdata_out = ~d;
    if (!keep_cs) cs_n_out = 1'b1;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic oe);
    @(posedge mclk_in);
    #1;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    addr_out = a;
    repeat (2) @(posedge mclk_in);
    #1;
    // A floated bus has no pull, so the model shows the inverse value.
    d = rd_oe_in ? rd_data_in : ~rd_data_in;
    oe = rd_oe_in;
    rd_n_out = 1'b1;
    if (!keep_cs) cs_n_out = 1'b1;
  endtask
  task automatic strobes_low(input bit on);
    @(posedge mclk_in);
    #1;
    cs_n_out = !on;
    rd_n_out = !on;
    wr_n_out = !on;
  endtask
  task automatic enter_tm0();
    write_reg(test_feature_control_addr, 8'h04);
    for (int i = 0; i < tm0_enable_count; i++) begin
      write_reg(tm0_enable_addr[i], 8'h00);
    end
  endtask
endmodule // host_port_model
`default_nettype wire

//--- sim/tb.sv
// Testbench for the board test control block.
// Assumes the host model drives the port; t_scan drives the scan port directly.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import board_test_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n, rd_n, wr_n, data_oe_out, normal_wr_out, pin_oe_out;
  logic subblock_test_out, factory_test_out;
  logic [7:0] addr, wdata, data_out, rd;
  logic [7:0] normal_rdata_in = 8'h6B;
  logic [15:0] pin_level_in = 16'h0000;
  logic [15:0] func_out_in = 16'hF0F0;
  logic [15:0] pin_out;
  logic oe;
  logic tck_in = 1'b0;
  logic tms_in = 1'b0;
  logic tdi_in = 1'b0;
  logic trst_n_in = 1'b0;
  logic tdo_out, tdo_oe_out;
  int errors = 0;
  int tests_run = 0;
  int wr_pulses = 0;
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (normal_wr_out === 1'b1) wr_pulses++;
  host_port_model u_host (.mclk_in(mclk_in), .rd_data_in(data_out),
    .rd_oe_in(data_oe_out), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));
  board_test_control u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr),
    .data_in(wdata), .normal_rdata_in(normal_rdata_in),
    .pin_level_in(pin_level_in), .func_out_in(func_out_in),
    .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in),
    .trst_n_in(trst_n_in),
    .data_out(data_out), .data_oe_out(data_oe_out),
    .normal_wr_out(normal_wr_out), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .subblock_test_out(subblock_test_out),
    .factory_test_out(factory_test_out), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out));
  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_reset();
    u_host.read_reg(test_feature_control_addr, rd, oe);
    check("ctrl", 16'h0000, {8'h00, rd & 8'h05});
    check("pin_oe", 16'h0001, {15'h0000, pin_oe_out});
    check("subblk", 16'h0000, {15'h0000, subblock_test_out});
    check("pins", func_out_in, pin_out);
  endtask
  task automatic t_normal();
    int n0;
    n0 = wr_pulses;
    u_host.write_reg(8'h12, 8'h55);
    u_host.write_reg(8'h81, 8'h00);
    u_host.read_reg(8'h12, rd, oe);
    check("nrd", 16'h006B, {8'h00, rd});
    check("nwr", 16'h0001, 16'(wr_pulses - n0));
    normal_rdata_in = 8'h94;
    u_host.read_reg(normal_last_addr, rd, oe);
    check("nrd_last", 16'h0194, {7'h00, oe, rd});
  endtask
  task automatic t_float();
    u_host.write_reg(test_feature_control_addr, 8'h01);
    settle();
    check("pin_oe", 16'h0000, {15'h0000, pin_oe_out});
    u_host.read_reg(test_feature_control_addr, rd, oe);
    check("rd", 16'h0101, {7'h00, oe, rd & 8'h05});
    u_host.write_reg(test_feature_control_addr, 8'h03);
    u_host.read_reg(test_feature_control_addr, rd, oe);
    check("bus_oe", 16'h0000, {15'h0000, oe});
    u_host.write_reg(test_feature_control_addr, 8'h0B);
    settle();
    check("cs_hi_oe", 16'h0001, {15'h0000, data_oe_out});
    u_host.keep_cs = 1'b1;
    u_host.write_reg(test_feature_control_addr, 8'h0B);
    settle();
    check("cs_lo_oe", 16'h0000, {15'h0000, data_oe_out});
    u_host.keep_cs = 1'b0;
    u_host.write_reg(test_feature_control_addr, 8'h00);
    settle();
    check("pin_oe", 16'h0001, {15'h0000, pin_oe_out});
  endtask
  task automatic t_strobes();
    u_host.strobes_low(1'b1);
    settle();
    check("pin_oe", 16'h0000, {15'h0000, pin_oe_out});
    check("bus_oe", 16'h0000, {15'h0000, data_oe_out});
    u_host.strobes_low(1'b0);
  endtask
  task automatic t_factory();
    u_host.keep_cs = 1'b1;
    u_host.write_reg(test_feature_control_addr, 8'h10);
    settle();
    check("factory", 16'h0001, {15'h0000, factory_test_out});
    check("subblk", 16'h0001, {15'h0000, subblock_test_out});
    u_host.write_reg(test_feature_control_addr, 8'h00);
    settle();
    check("factory", 16'h0001, {15'h0000, factory_test_out});
    u_host.keep_cs = 1'b0;
    u_host.strobes_low(1'b0);
    settle();
    check("factory", 16'h0000, {15'h0000, factory_test_out});
    check("subblk", 16'h0000, {15'h0000, subblock_test_out});
  endtask
  task automatic t_tm0();
    u_host.enter_tm0();
    u_host.write_reg(tm0_out_lo_addr, 8'hA5);
    u_host.write_reg(tm0_out_hi_addr, 8'h3C);
    settle();
    check("pins", 16'h3CA5, pin_out);
    pin_level_in = 16'h1234;
    u_host.read_reg(tm0_in_lo_addr, rd, oe);
    check("lvl_lo", 16'h0134, {7'h00, oe, rd});
    u_host.read_reg(tm0_in_hi_addr, rd, oe);
    check("lvl_hi", 16'h0112, {7'h00, oe, rd});
    u_host.write_reg(test_feature_control_addr, 8'h00);
    settle();
    check("pins", func_out_in, pin_out);
  endtask
  // One scan clock pulse: high for one system clock, low for the next.
  task automatic tck_pulse(input logic tms, input logic tdi);
    @(posedge mclk_in);
    #1;
    tms_in = tms;
    tdi_in = tdi;
    tck_in = 1'b1;
    @(posedge mclk_in);
    #1;
    tck_in = 1'b0;
  endtask
  task automatic t_scan();
    logic [31:0] cap;
    logic [31:0] pat;
    cap = {pin_level_in, func_out_in};
    pat = 32'h0000_C35A;
    trst_n_in = 1'b1;
    tck_pulse(1'b0, 1'b0);
    tck_pulse(1'b1, 1'b0);
    for (int k = 0; k < 32; k++) begin
      tck_pulse(k == 31, pat[k]);
      check("tdo", {15'h0000, cap[k]}, {15'h0000, tdo_out});
      check("tdo_oe", 16'h0001, {15'h0000, tdo_oe_out});
    end
    tck_pulse(1'b1, 1'b0);
    repeat (2) tck_pulse(1'b0, 1'b0);
    tck_pulse(1'b1, 1'b0);
    tck_pulse(1'b0, 1'b0);
    settle();
    check("scan_pins", pat[15:0], pin_out);
    trst_n_in = 1'b0;
    settle();
    check("pins", func_out_in, pin_out);
    check("tdo_oe", 16'h0000, {15'h0000, tdo_oe_out});
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset();
    t_normal();
    t_float();
    t_strobes();
    t_factory();
    t_tm0();
    t_scan();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
